// ===== spc_defines.svh
// constants of the sleep and power-reduction controller: offsets, fields,
// reset values and wake timing counts; included by the package and top
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// ---------------------------------------------------------------------
// register byte offsets on the avalon slave
// ---------------------------------------------------------------------
`define SPC_OFF_MCU_CTRL    4'h0
`define SPC_OFF_PWR_RED     4'h4
`define SPC_OFF_CONFIG      4'h8
`define SPC_OFF_STATUS      4'hC

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define SPC_SLEEP_ALLOW_BIT 5
`define SPC_MODE_MSB        4
`define SPC_MODE_LSB        3
`define SPC_PR_ADC_BIT      0
`define SPC_CFG_XTAL_BIT    0
`define SPC_CFG_INT0LVL_BIT 1
`define SPC_CFG_ADCEN_BIT   2
`define SPC_CFG_ADCREF_BIT  3
`define SPC_CFG_CMPOFF_BIT  4
`define SPC_CFG_CMPREF_BIT  5
`define SPC_CFG_WDTEN_BIT   6

// ---------------------------------------------------------------------
// sleep mode select codes and reset values
// ---------------------------------------------------------------------
`define SPC_MODE_IDLE       2'h0
`define SPC_MODE_NOISE      2'h1
`define SPC_MODE_PDOWN      2'h2
`define SPC_MODE_STBY       2'h3
`define SPC_MCU_CTRL_RST    3'h0
`define SPC_PWR_RED_RST     4'h0
`define SPC_CONFIG_RST      7'h00

// ---------------------------------------------------------------------
// wake timing in clock cycles
// ---------------------------------------------------------------------
`define SPC_STBY_WAKE_CYC   6
`define SPC_IRQ_HALT_CYC    4

`endif

// ===== spc_pkg.sv
// types shared by the sleep and power-reduction controller
// assumes spc_defines.svh sits in the include path
package spc_pkg;
	`include "spc_defines.svh"

	// controller sequence states
	typedef enum logic [2:0] {
		ST_ACTIVE,
		ST_SLEEP,
		ST_START,
		ST_HALT,
		ST_RESUME
	} spc_state_type;

	// clock domain and oscillator enables
	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic osc;
	} spc_clk_gate_type;

	// software configuration held beside the sleep fields
	typedef struct packed {
		logic wdt_en;
		logic cmp_int_ref;
		logic cmp_off;
		logic adc_ref;
		logic adc_en;
		logic external_irq_line_zero_level;
		logic xtal;
	} spc_cfg_type;
endpackage

// ===== spc_sleep_ctrl.sv
// sleep mode and peripheral power-reduction controller, one clock domain
// assumes a core that pulses sleep_instr_in and waits on core_halt_out,
// and wake sources that are synchronous to sys_clk_in
//
// Overview of operation
// - sleep instruction enters selected mode only when sleep-allow is one.
// - mode 00 idle stops core and flash clocks, others keep running.
// - idle wakes on any enabled interrupt, internal or external.
// - mode 01 noise reduction keeps only converter clock and oscillator.
// - noise mode wakes on conversion, store-ready, level line zero, pins, resets.
// - mode 10 power-down stops oscillator and every generated clock.
// - power-down wakes only on resets, level line zero, pin change.
// - mode 11 with crystal is standby: power-down with oscillator running.
// - standby wake-up latency is six clock cycles.
// - interrupt wake halts core four cycles past start-up, then handler.
// - register file and sram contents survive sleep and wake-up.
// - reset during sleep wakes the core at the reset vector.
// - converter enabled: entering idle or noise mode starts a conversion.
// - line zero wakes noise and power-down only when level sensed.
// - power reduction bit stops that peripheral clock in any mode.
// - stopped peripheral is frozen and its registers are blocked.
// - clearing the bit restarts the clock, peripheral state unchanged.
// - io and converter clocks both off: digital input buffers disabled.
// - power-down and standby force comparator off unless it uses vref.
// - enabled watchdog and converter stay enabled in every sleep mode.
// - brown-out detector stays active in sleep when its fuses enable it.
// - voltage reference powered only while detector, comparator or adc need it.
// - sleep-allow is control bit 5, mode select is bits 4 and 3.
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`include "spc_defines.svh"
module spc_sleep_ctrl
	import spc_pkg::*;
#(
	parameter int OSC_START_CYC = 16
) (
	input  wire logic             sys_clk_in,
	input  wire logic             reset_n_in,
	input  wire logic [3:0]       avs_address_in,
	input  wire logic             avs_read_in,
	input  wire logic             avs_write_in,
	input  wire logic [31:0]      avs_writedata_in,
	input  wire logic [3:0]       avs_byteenable_in,
	output logic      [31:0]      avs_readdata_out,
	output logic                  avs_waitrequest_out,
	input  wire logic             sleep_instr_in,
	input  wire logic             irq_pending_in,
	input  wire logic             adc_done_irq_in,
	input  wire logic             store_ready_irq_in,
	input  wire logic             wdt_irq_in,
	input  wire logic             pin_change_irq_in,
	input  wire logic             external_irq_line_zero_irq_in,
	input  wire logic             ext_reset_in,
	input  wire logic             wdt_reset_in,
	input  wire logic             bod_reset_in,
	input  wire logic             bod_fuse_en_in,
	output spc_clk_gate_type      clk_gate_out,
	output logic      [3:0]       periph_clk_en_out,
	output logic      [3:0]       periph_reg_block_out,
	output logic                  core_halt_out,
	output logic                  irq_take_out,
	output logic                  reset_vector_out,
	output logic                  adc_start_out,
	output logic                  adc_en_out,
	output logic                  wdt_en_out,
	output logic                  bod_en_out,
	output logic                  vref_en_out,
	output logic                  comparator_power_off_out,
	output logic                  input_buf_en_out,
	output logic                  wake_buf_en_out
);

	// ---------------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------------
	if (OSC_START_CYC < 1 || OSC_START_CYC > 255) begin : g_bad_start
		$error("OSC_START_CYC must lie in 1..255");
	end

	localparam logic [7:0] START_CNT = 8'(OSC_START_CYC - 1);
	localparam logic [7:0] STBY_CNT  = 8'(`SPC_STBY_WAKE_CYC - 1);
	localparam logic [7:0] HALT_CNT  = 8'(`SPC_IRQ_HALT_CYC - 1);

	// ---------------------------------------------------------------------
	// reset release through two flip-flops
	// ---------------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// ---------------------------------------------------------------------
	// helper functions
	// ---------------------------------------------------------------------
	// mode 11 without a crystal falls back to power-down, oscillator off
	function automatic logic is_deep(input logic [1:0] m);
		is_deep = (m == `SPC_MODE_PDOWN) || (m == `SPC_MODE_STBY);
	endfunction

	function automatic logic is_stby(input logic [1:0] m, input logic x);
		is_stby = (m == `SPC_MODE_STBY) && x;
	endfunction

	// clock enables per state; the core is frozen, never cleared
	function automatic spc_clk_gate_type gates(input spc_state_type s,
			input logic [1:0] m, input logic x);
		spc_clk_gate_type g;
		g = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, osc: 1'b1};
		unique case (s)
			ST_ACTIVE, ST_RESUME: ;
			ST_SLEEP: begin
				g.cpu   = 1'b0;
				g.flash = 1'b0;
				g.io    = (m == `SPC_MODE_IDLE);
				g.adc   = !is_deep(m);
				g.osc   = !is_deep(m) || is_stby(m, x);
			end
			ST_START: begin
				g = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, adc: 1'b0, osc: 1'b1};
			end
			ST_HALT: begin
				g.cpu   = 1'b0;
				g.flash = 1'b0;
			end
		endcase
		return g;
	endfunction

	// ---------------------------------------------------------------------
	// register file and avalon slave
	// ---------------------------------------------------------------------
	logic [2:0]    mcu_ctrl_q, mcu_ctrl_d;   // allow, mode[1:0]
	logic [3:0]    pwr_red_q, pwr_red_d;
	spc_cfg_type   cfg_q, cfg_d;
	logic          ack_q, ack_d, wait_q, wait_d;
	logic [31:0]   rdata_q, rdata_d;
	spc_state_type state_q, state_d;
	logic [1:0]    mode_lat_q, mode_lat_d;
	logic          by_reset_q, by_reset_d;
	logic          sleep_allow;
	logic [1:0]    mode_sel;

	assign sleep_allow = mcu_ctrl_q[2];
	assign mode_sel    = mcu_ctrl_q[1:0];

	// one wait cycle per access; write lands on the edge waitrequest is low
	always_comb begin
		mcu_ctrl_d = mcu_ctrl_q;
		pwr_red_d  = pwr_red_q;
		cfg_d      = cfg_q;
		rdata_d    = rdata_q;
		ack_d      = (avs_read_in || avs_write_in) && !ack_q;
		wait_d     = !ack_d;
		if (avs_read_in && !ack_q) begin
			unique case (avs_address_in)
				`SPC_OFF_MCU_CTRL:
					rdata_d = {26'h0, mcu_ctrl_q, 3'h0};
				`SPC_OFF_PWR_RED:
					rdata_d = {28'h0, pwr_red_q};
				`SPC_OFF_CONFIG:
					rdata_d = {25'h0, cfg_q};
				`SPC_OFF_STATUS:
					rdata_d = {25'h0, by_reset_q, mode_lat_q,
						state_q != ST_ACTIVE, state_q};
				default:
					rdata_d = 32'h0;   // unmapped reads answer zero
			endcase
		end
		if (avs_write_in && ack_q && avs_byteenable_in[0]) begin
			unique case (avs_address_in)
				`SPC_OFF_MCU_CTRL:
					mcu_ctrl_d = avs_writedata_in[`SPC_SLEEP_ALLOW_BIT:
						`SPC_MODE_LSB];
				`SPC_OFF_PWR_RED:
					pwr_red_d = avs_writedata_in[3:0];
				`SPC_OFF_CONFIG:
					cfg_d = avs_writedata_in[6:0];
				default: ;   // status and unmapped ignore writes
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mcu_ctrl_q <= `SPC_MCU_CTRL_RST;
			pwr_red_q  <= `SPC_PWR_RED_RST;
			cfg_q      <= `SPC_CONFIG_RST;
			ack_q      <= 1'b0;
			wait_q     <= 1'b1;
			rdata_q    <= 32'h0;
		end else begin
			mcu_ctrl_q <= mcu_ctrl_d;
			pwr_red_q  <= pwr_red_d;
			cfg_q      <= cfg_d;
			ack_q      <= ack_d;
			wait_q     <= wait_d;
			rdata_q    <= rdata_d;
		end
	end

	// ---------------------------------------------------------------------
	// wake decode
	// ---------------------------------------------------------------------
	logic reset_src;
	logic external_irq_line_zero_lvl;
	logic wake_irq;

	assign reset_src = ext_reset_in || wdt_reset_in || bod_reset_in;
	// edge-sensed line zero cannot wake deeper modes
	assign external_irq_line_zero_lvl  = external_irq_line_zero_irq_in && cfg_q.external_irq_line_zero_level;

	always_comb begin
		unique case (mode_lat_q)
			`SPC_MODE_IDLE:
				wake_irq = irq_pending_in || adc_done_irq_in ||
					store_ready_irq_in || wdt_irq_in ||
					pin_change_irq_in || external_irq_line_zero_irq_in;
			`SPC_MODE_NOISE:
				wake_irq = adc_done_irq_in || store_ready_irq_in ||
					wdt_irq_in || pin_change_irq_in || external_irq_line_zero_lvl;
			default:
				wake_irq = pin_change_irq_in || external_irq_line_zero_lvl;
		endcase
	end

	// ---------------------------------------------------------------------
	// sleep sequence
	// ---------------------------------------------------------------------
	logic [7:0] cnt_q, cnt_d;
	logic       adc_kick;

	always_comb begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		mode_lat_d = mode_lat_q;
		by_reset_d = by_reset_q;
		adc_kick   = 1'b0;
		unique case (state_q)
			ST_ACTIVE: begin
				if (sleep_instr_in && sleep_allow) begin
					state_d    = ST_SLEEP;
					mode_lat_d = mode_sel;
					by_reset_d = 1'b0;
					adc_kick   = cfg_q.adc_en && !is_deep(mode_sel);
				end
			end
			ST_SLEEP: begin
				if (reset_src || wake_irq) begin
					by_reset_d = reset_src;
					if (!is_deep(mode_lat_q)) begin
						state_d = reset_src ? ST_RESUME : ST_HALT;
						cnt_d   = HALT_CNT;
					end else begin
						state_d = ST_START;
						cnt_d   = is_stby(mode_lat_q, cfg_q.xtal) ?
							STBY_CNT : START_CNT;
					end
				end
			end
			ST_START: begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h00) begin
					state_d = by_reset_q ? ST_RESUME : ST_HALT;
					cnt_d   = HALT_CNT;
				end
			end
			ST_HALT: begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h00)
					state_d = ST_RESUME;
			end
			ST_RESUME: state_d = ST_ACTIVE;
			default:   state_d = ST_ACTIVE;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= ST_ACTIVE;
			cnt_q      <= 8'h00;
			mode_lat_q <= `SPC_MODE_IDLE;
			by_reset_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			mode_lat_q <= mode_lat_d;
			by_reset_q <= by_reset_d;
		end
	end

	// ---------------------------------------------------------------------
	// registered outputs, computed from the next state so they line up
	// with state_q; bus writes reach the outputs on the same edge, no added latency
	// ---------------------------------------------------------------------
	spc_clk_gate_type gate_q, gate_d;
	logic [3:0] pclk_q, pclk_d;
	logic       halt_q, halt_d, take_q, take_d, rvec_q, rvec_d;
	logic       kick_q, cmp_off_q, cmp_off_d, inbuf_q, inbuf_d;
	logic       vref_q, vref_d, deep_d;

	always_comb begin
		gate_d = gates(state_d, mode_lat_d, cfg_d.xtal);
		deep_d = (state_d == ST_SLEEP) && is_deep(mode_lat_d);
		// per-peripheral gate on top of the domain clock
		pclk_d = {gate_d.io, gate_d.io, gate_d.io, gate_d.adc} & ~pwr_red_d;
		halt_d = state_d != ST_ACTIVE;
		take_d = (state_d == ST_RESUME) && !by_reset_d;
		// reset wake goes to the vector
		rvec_d = (state_d == ST_RESUME) && by_reset_d;
		cmp_off_d = cfg_d.cmp_off || (deep_d && !cfg_d.cmp_int_ref);
		// input buffers off when io and adc clocks stop
		inbuf_d = gate_d.io || gate_d.adc;
		vref_d = bod_fuse_en_in || (cfg_d.adc_en && cfg_d.adc_ref) ||
			(!cmp_off_d && cfg_d.cmp_int_ref);
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			gate_q    <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1,
				osc: 1'b1};
			pclk_q    <= 4'hF;
			halt_q    <= 1'b0;
			take_q    <= 1'b0;
			rvec_q    <= 1'b0;
			kick_q    <= 1'b0;
			cmp_off_q <= 1'b0;
			inbuf_q   <= 1'b1;
			vref_q    <= 1'b0;
		end else begin
			gate_q    <= gate_d;
			pclk_q    <= pclk_d;
			halt_q    <= halt_d;
			take_q    <= take_d;
			rvec_q    <= rvec_d;
			kick_q    <= adc_kick;
			cmp_off_q <= cmp_off_d;
			inbuf_q   <= inbuf_d;
			vref_q    <= vref_d;
		end
	end

	// core held by gating only; blocked while reduced
	assign clk_gate_out             = gate_q;
	assign periph_clk_en_out        = pclk_q;
	assign periph_reg_block_out     = pwr_red_q;
	assign core_halt_out            = halt_q;
	assign irq_take_out             = take_q;
	assign reset_vector_out         = rvec_q;
	assign adc_start_out            = kick_q;
	// enables pass through untouched by sleep
	assign adc_en_out               = cfg_q.adc_en;
	assign wdt_en_out               = cfg_q.wdt_en;
	assign comparator_power_off_out = cmp_off_q;
	assign input_buf_en_out         = inbuf_q;
	assign wake_buf_en_out          = rst_sync_q[1];   // wake pins always
	assign vref_en_out              = vref_q;
	assign avs_readdata_out         = rdata_q;
	assign avs_waitrequest_out      = wait_q;   // own flop, no inverter

	// detector follows its fuses in every mode
	logic bod_q;
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n)
			bod_q <= 1'b0;
		else
			bod_q <= bod_fuse_en_in;
	end
	assign bod_en_out = bod_q;

	// ---------------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n);

	a_sleep_not_allowed: assert property (
		state_q == ST_ACTIVE && sleep_instr_in && !sleep_allow
		|=> state_q == ST_ACTIVE && !core_halt_out)
		else $error("sleep entered without sleep-allow");

	a_idle_clocks: assert property (
		state_q == ST_SLEEP && mode_lat_q == `SPC_MODE_IDLE
		|-> !gate_q.cpu && !gate_q.flash && gate_q.io && gate_q.adc &&
			gate_q.osc)
		else $error("idle clock gating wrong");

	a_noise_clocks: assert property (
		state_q == ST_SLEEP && mode_lat_q == `SPC_MODE_NOISE
		|-> !gate_q.io && !gate_q.cpu && gate_q.adc && gate_q.osc)
		else $error("noise mode clock gating wrong");

	a_pdown_clocks: assert property (
		state_q == ST_SLEEP && mode_lat_q == `SPC_MODE_PDOWN
		|-> gate_q == '0)
		else $error("power-down left a clock running");

	a_stby_osc: assert property (
		state_q == ST_SLEEP && is_stby(mode_lat_q, cfg_q.xtal)
		|-> gate_q.osc && !gate_q.io && !gate_q.adc)
		else $error("standby oscillator wrong");

	a_deep_no_wake: assert property (
		state_q == ST_SLEEP && is_deep(mode_lat_q) && !reset_src &&
		!pin_change_irq_in && !external_irq_line_zero_lvl
		|=> state_q == ST_SLEEP)
		else $error("deep sleep woke on a foreign source");

	a_stby_latency: assert property (
		state_q == ST_SLEEP && is_stby(mode_lat_q, cfg_q.xtal) &&
		pin_change_irq_in && !reset_src
		|=> (state_q == ST_START) [*6] ##1 state_q == ST_HALT)
		else $error("standby wake latency not six cycles");

	a_halt_four: assert property (
		state_q != ST_HALT ##1 state_q == ST_HALT
		|-> (core_halt_out && !gate_q.cpu) [*4] ##1
			(state_q == ST_RESUME && irq_take_out))
		else $error("interrupt halt not four cycles");

	a_reset_vector: assert property (
		state_q == ST_SLEEP && reset_src
		|-> ##[1:300] reset_vector_out && !irq_take_out)
		else $error("reset in sleep missed the vector");

	a_adc_autostart: assert property (
		state_q == ST_ACTIVE && sleep_instr_in && sleep_allow &&
		cfg_q.adc_en && !is_deep(mode_sel)
		|=> adc_start_out && state_q == ST_SLEEP)
		else $error("conversion not started on entry");

	a_prr_gate: assert property (
		(pwr_red_q & $past(pwr_red_q) & periph_clk_en_out) == 4'h0)
		else $error("reduced peripheral still clocked");

	a_inbuf_off: assert property (
		state_q == ST_SLEEP && is_deep(mode_lat_q)
		|-> !input_buf_en_out && wake_buf_en_out)
		else $error("input buffers left on");

	a_cmp_deep: assert property (
		state_q == ST_SLEEP && is_deep(mode_lat_q) && !cfg_q.cmp_int_ref
		|-> comparator_power_off_out)
		else $error("comparator not forced off");

	c_idle_wake:  cover property (state_q == ST_SLEEP &&
		mode_lat_q == `SPC_MODE_IDLE ##1 state_q == ST_HALT);
	c_stby_wake:  cover property (state_q == ST_START ##1
		state_q == ST_HALT);
	c_reset_wake: cover property (reset_vector_out);
	c_prr_stop:   cover property (state_q == ST_ACTIVE &&
		periph_clk_en_out != 4'hF);

endmodule

// ===== spc_core_model.sv
// core-side partner: turns a held bench sleep request into one-cycle sleep
// pulses every other cycle. assumes one clock shared with the sleep controller
module spc_core_model (
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	input  wire logic req_in,
	input  wire logic halt_in,
	output logic      sleep_instr_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// sleep instruction issue
	// ---------------------------------------------------------------
	// issue while running
	// a halted core executes nothing, so no pulse while halt is high
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			sleep_instr_out <= 1'b0;
		else
			sleep_instr_out <= req_in & ~halt_in & ~sleep_instr_out;
	end
endmodule

// ===== tb_top.sv
// self-checking bench for the sleep and power-reduction controller
// assumes spc_pkg compiled first and spc_core_model as the core side
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic                     clk = 1'b0;
	logic                     rst_n = 1'b0;
	logic [3:0]               addr = 4'h0;
	logic [3:0]               be = 4'hF;
	logic                     rd = 1'b0;
	logic                     wr = 1'b0;
	logic [31:0]              wdata = 32'h0;
	logic                     sreq = 1'b0;
	logic [5:0]               src = 6'h00;
	logic [2:0]               rsrc = 3'h0;
	logic                     bod = 1'b0;
	logic                     arm = 1'b0;
	logic [7:0]               lat = 8'h00;
	logic                     ph = 1'b0;
	logic [3:0]               pb = 4'h0;
	logic [3:0]               power_reduction_reg = 4'h0;
	logic [31:0]              rdata;
	logic                     waitreq;
	logic                     sleep_i;
	spc_pkg::spc_clk_gate_type gate;
	logic [3:0]               pclk;
	logic [3:0]               blk;
	logic                     halt, itake, rvec, adcst, adcen;
	logic                     wdten, boden, vref, cmpoff, ibuf, wbuf;
	logic [33:0]              q[$];
	int                       miscompares = 0;
	int                       n_checks = 0;

	// short start-up keeps the power-down wake quick
	spc_sleep_ctrl #(.OSC_START_CYC(4)) spc_sleep_ctrl_i (
		.sys_clk_in(clk), .reset_n_in(rst_n), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq), .sleep_instr_in(sleep_i),
		.irq_pending_in(src[0]), .adc_done_irq_in(src[1]),
		.store_ready_irq_in(src[2]), .wdt_irq_in(src[3]),
		.pin_change_irq_in(src[4]), .external_irq_line_zero_irq_in(src[5]),
		.ext_reset_in(rsrc[0]), .wdt_reset_in(rsrc[1]),
		.bod_reset_in(rsrc[2]), .bod_fuse_en_in(bod),
		.clk_gate_out(gate), .periph_clk_en_out(pclk),
		.periph_reg_block_out(blk), .core_halt_out(halt),
		.irq_take_out(itake), .reset_vector_out(rvec),
		.adc_start_out(adcst), .adc_en_out(adcen), .wdt_en_out(wdten),
		.bod_en_out(boden), .vref_en_out(vref),
		.comparator_power_off_out(cmpoff), .input_buf_en_out(ibuf),
		.wake_buf_en_out(wbuf));

	spc_core_model spc_core_model_i (.clk_in(clk), .reset_n_in(rst_n),
		.req_in(sreq), .halt_in(halt), .sleep_instr_out(sleep_i));

	initial begin
		forever #4 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// closing, comparison and bus tasks
	// ---------------------------------------------------------------
	task automatic conclude();
		if (q.size() != 0)
			miscompares++;
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// oldest note against the result just seen; a result with no note
	// means the block woke or moved when it should have stayed put
	task automatic take(input logic [33:0] v);
		logic [33:0] x;
		n_checks++;
		if (q.size() == 0) begin
			miscompares++;
			$display("[ERR] kind %0d exp none got %h", v[33:32], v[31:0]);
		end else begin
			x = q.pop_front();
			if (x !== v) begin
				miscompares++;
				$display("[ERR] kind %0d exp %h got %h", v[33:32], x[31:0],
					v[31:0]);
			end
		end
	endtask

	// one avalon access; held until waitrequest is sampled low
	task automatic acc(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] e);
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= d;
		be <= e;
		// no cycle limit here: only the watchdog ends a stuck access
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rdc(input logic [3:0] a, input logic [31:0] d);
		q.push_back({2'h0, d});
		acc(1'b0, a, 32'h0, 4'hF);
	endtask

	task automatic waitfor(input logic want);
		int n;
		n = 0;
		while (halt !== want && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100)
			miscompares++;
	endtask

	// sleep in mode m, try refused sources, then wake by good or reset
	task automatic run(input logic [1:0] m, input logic x, input logic lv,
		input logic [5:0] good, input logic [2:0] rs, input logic [7:0] l);
		logic [6:0] c;
		logic [4:0] g;
		logic [5:0] bad;
		logic       co;
		c = 7'($urandom) & 7'h7C | {5'h00, lv, x};
		g = (m == 2'h0) ? 5'h07 : (m == 2'h1) ? 5'h03 : (m == 2'h3 && x) ?
			5'h01 : 5'h00;
		co = c[4] | (m[1] & ~c[5]);
		bad = (m == 2'h0) ? 6'h00 : m[1] ? 6'h0F : 6'h01;
		if (!lv && m != 2'h0)
			bad = bad | 6'h20;
		acc(1'b1, 4'h8, {25'h0, c}, 4'hF);
		acc(1'b1, 4'h0, {26'h0, 1'b1, m, 3'h0}, 4'hF);
		q.push_back({17'h0, 1'b1, ~power_reduction_reg & {g[2], g[2], g[2], g[1]}, g,
			g[2] | g[1],
			co, c[2] & ~m[1], c[2], c[6], bod,
			bod | (c[2] & c[3]) | (c[5] & ~co)} | 34'h100000000);
		sreq <= 1'b1;
		waitfor(1'b1);
		sreq <= 1'b0;
		rdc(4'hC, {25'h0, 1'b0, m, 1'b1, 3'h1});
		src <= bad;
		repeat (8) @(posedge clk);
		q.push_back({2'h2, 22'h0, l, |rs, ~|rs});
		arm <= 1'b1;
		src <= (rs == 3'h0) ? good : 6'h00;
		rsrc <= rs;
		waitfor(1'b0);
		arm <= 1'b0;
		src <= 6'h00;
		rsrc <= 3'h0;
		rdc(4'hC, {25'h0, |rs, m, 1'b0, 3'h0});
	endtask

	// ---------------------------------------------------------------
	// result watcher
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		lat <= arm ? lat + 8'h01 : 8'h00;
		ph <= halt;
		pb <= blk;
		if (rst_n) begin
			if (rd && !waitreq)
				take({2'h0, rdata});
			if (halt && !ph)
				take({2'h1, 15'h0, wbuf, pclk, gate, ibuf, cmpoff, adcst, adcen,
					wdten, boden, vref});
			if (itake || rvec)
				take({2'h2, 22'h0, lat, rvec, itake});
			if (blk !== pb)
				take({2'h3, 24'h0, pclk, blk});
		end
	end

	// hang guard, well past the expected few hundred cycles
	initial begin
		#400000;
		miscompares++;
		conclude();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [3:0] v;
		void'($urandom(55993));
		bod <= 1'($urandom);
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rdc(4'h0, 32'h0);
		rdc(4'h4, 32'h0);
		rdc(4'h8, 32'h0);
		rdc(4'h2, 32'h0);
		acc(1'b1, 4'hC, 32'h7F, 4'hF);
		rdc(4'hC, 32'h0);
		acc(1'b1, 4'h0, 32'h38, 4'h0);
		rdc(4'h0, 32'h0);
		acc(1'b1, 4'h0, 32'h10, 4'hF);
		sreq <= 1'b1;
		repeat (10) @(posedge clk);
		sreq <= 1'b0;
		rdc(4'h0, 32'h10);
		for (int i = 0; i < 3; i++) begin
			v = power_reduction_reg ^ 4'(($urandom % 15) + 1);
			q.push_back({2'h3, 24'h0, ~v, v});
			acc(1'b1, 4'h4, {28'h0, v}, 4'hF);
			power_reduction_reg = v;
			rdc(4'h4, {28'h0, v});
		end
		run(2'h0, 1'b0, 1'b0, 6'h01, 3'h0, 8'h05);
		run(2'h1, 1'b0, 1'b0, 6'h02, 3'h0, 8'h05);
		run(2'h1, 1'b0, 1'b1, 6'h20, 3'h0, 8'h05);
		run(2'h1, 1'b0, 1'b0, 6'h04, 3'h0, 8'h05);
		run(2'h2, 1'b0, 1'b0, 6'h10, 3'h0, 8'h09);
		run(2'h2, 1'b0, 1'b1, 6'h20, 3'h0, 8'h09);
		run(2'h3, 1'b1, 1'b0, 6'h10, 3'h0, 8'h0B);
		run(2'h3, 1'b0, 1'b0, 6'h10, 3'h0, 8'h09);
		run(2'h0, 1'b0, 1'b0, 6'h00, 3'h1, 8'h01);
		run(2'h1, 1'b0, 1'b0, 6'h00, 3'h2, 8'h01);
		run(2'h2, 1'b0, 1'b0, 6'h00, 3'h4, 8'h05);
		run(2'h3, 1'b1, 1'b0, 6'h00, 3'h1, 8'h07);
		repeat (4) @(posedge clk);
		conclude();
	end
endmodule
